// ===== verilog/gps_pkg.sv
package gps_pkg;

	// Bus geometry: register index lives in adr_i[7:2]
	localparam int unsigned WB_ADR_W  = 8;
	localparam int unsigned WB_DAT_W  = 32;
	localparam int unsigned REG_W     = 16;
	localparam int unsigned IDX_W     = 6;
	localparam int unsigned IDX_LSB   = 2;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_GIG_ADVERT_CONTROL  = 6'h09;
	localparam logic [IDX_W-1:0] IDX_GIG_LINK_STATUS     = 6'h0A;
	localparam logic [IDX_W-1:0] IDX_GIG_ABILITY_STATUS  = 6'h0F;
	localparam logic [IDX_W-1:0] IDX_STRAP_CAPTURE       = 6'h10;

	// Gigabit advertisement control fields
	localparam int unsigned ADV_MULTI_PORT_BIT = 10;
	localparam int unsigned ADV_1000FD_BIT     = 9;
	localparam int unsigned ADV_1000HD_BIT     = 8;
	localparam int unsigned ADV_WR_LANE        = 1;

	// Gigabit link status fields
	localparam int unsigned LS_MS_FAULT_BIT    = 15;
	localparam int unsigned LS_MS_MASTER_BIT   = 14;
	localparam int unsigned LS_LOCAL_RX_BIT    = 13;
	localparam int unsigned LS_REMOTE_RX_BIT   = 12;
	localparam int unsigned LS_LP_1000FD_BIT   = 11;
	localparam int unsigned LS_LP_1000HD_BIT   = 10;
	localparam int unsigned IDLE_CNT_W         = 8;
	localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_MAX  = 8'hFF;
	localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_ZERO = 8'h00;
	localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_ONE  = 8'h01;

	// Fixed ability word: copper full and half duplex only
	localparam logic [REG_W-1:0] ABILITY_STATUS_VALUE = 16'h3000;

	// Strap capture fields
	localparam int unsigned SC_AN_EN_BIT     = 15;
	localparam int unsigned SC_DUPLEX_BIT    = 14;
	localparam int unsigned SC_SPEED_LSB     = 12;
	localparam int unsigned SC_NC_MODE_BIT   = 10;
	localparam int unsigned SC_MAC_CLK_BIT   = 7;
	localparam int unsigned SC_XOVER_BIT     = 6;
	localparam int unsigned SC_MULTI_BIT     = 5;
	localparam int unsigned SC_ADDR_LSB      = 0;

	// Speed strap code that selects gigabit operation
	localparam logic [1:0] SPEED_1000 = 2'h2;

	// Strap pins as sampled while reset is held
	typedef struct packed {
		logic       an_en;
		logic       duplex;
		logic [1:0] speed;
		logic       nc_mode;
		logic       mac_clk_en;
		logic       auto_crossover_strap;
		logic       multi_port;
		logic [4:0] mgmt_address_strap;
	} gps_strap_s;

	// Link-side status and events from the gigabit PCS
	typedef struct packed {
		logic ms_fault;
		logic ms_master;
		logic local_rx_ok;
		logic remote_rx_ok;
		logic lp_1000fd;
		logic lp_1000hd;
		logic idle_err;
	} gps_link_s;

	// Preset values handed to registers held elsewhere
	typedef struct packed {
		logic       basic_an_en;
		logic       basic_duplex;
		logic       basic_speed_msb;
		logic       basic_speed_lsb;
		logic       aux_nc_mode;
		logic       aux_auto_crossover;
		logic       mac_clk_en;
		logic [4:0] mgmt_address;
	} gps_preset_s;

endpackage

// ===== verilog/gps_strap_capture.sv
`timescale 1ns/100ps
module gps_strap_capture
	import gps_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Strap pins and captured copy
	input  wire gps_strap_s strap_i,
	output gps_strap_s      strap_o
);

	gps_strap_s strap_q;

	// Follow the pins while reset is held, freeze at release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_q <= strap_i;
		end
	end

	assign strap_o = strap_q;

endmodule

// ===== verilog/gps_sat_counter.sv
`timescale 1ns/100ps
module gps_sat_counter
	import gps_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Count and clear strobes
	input  wire logic                  inc_i,
	input  wire logic                  clr_i,
	// Current count
	output logic [IDLE_CNT_W-1:0]      cnt_o
);

	logic [IDLE_CNT_W-1:0] cnt_q;

	// Saturating count; an event on the clearing edge survives as one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= IDLE_CNT_ZERO;
		end else if (clr_i) begin
			cnt_q <= inc_i ? IDLE_CNT_ONE : IDLE_CNT_ZERO;
		end else if (inc_i && cnt_q != IDLE_CNT_MAX) begin
			cnt_q <= cnt_q + IDLE_CNT_ONE;
		end
	end

	assign cnt_o = cnt_q;

endmodule

// ===== verilog/gps_regs.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
// Functional notes
// - Advert bit 9 is read/write; set advertises gigabit full duplex.
// - Advert bit 8 is read/write; set advertises gigabit half duplex.
// - Reset value of both advert bits derives from negotiation, duplex and speed straps.
// - Advert bits 7:0 ignore writes and read zero.
// - Status bit 15 latches master/slave fault, clears after being read.
// - Status bit 14 shows master/slave resolution, one means master.
// - Status bits 11,10 show partner full/half gigabit ability, reset zero; the code passes link_i through live, with no reset.
// - Status bits 9:8 and ability bits 11:0 ignore writes, read zero.
// - Ability bits 15,14 always read zero, no fiber gigabit.
// - Ability bits 13,12 fixed one, copper full and half duplex.
// - Strap bit 15 shows negotiation strap, presets basic control bit 12.
// - Strap bit 14 shows duplex strap, presets basic control bit 8.
// - Strap bits 13:12 show speed strap, preset basic bits 6 and 13.
// - Strap bit 10 shows non-standard strap, presets auxiliary bit 9.
// - Strap bit 7 shows MAC clock output enable strap.
// - Strap bit 6 shows crossover strap, presets auxiliary bit 15.
// - Strap bit 5 shows multi-port strap, presets advert bit 10.
// - Strap bits 4:0 show management address, preset address register.
// - Strap bits 11,9,8 written zero by software, read value meaningless.
// - Strap contents change only at reset, never by software writes.
module gps_regs
	import gps_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone classic slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [WB_ADR_W-1:0]  adr_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [WB_DAT_W-1:0]  dat_i,
	output logic                      ack_o,
	output logic [WB_DAT_W-1:0]       dat_o,
	// Strap pins, sampled during reset
	input  wire gps_strap_s           strap_i,
	// Gigabit link status and events
	input  wire gps_link_s            link_i,
	// Advertisement toward negotiation logic
	output logic                      adv_1000fd_o,
	output logic                      adv_1000hd_o,
	output logic                      adv_multi_port_o,
	// Presets for registers held elsewhere
	output gps_preset_s               preset_o
);

	// Bus handshake state
	logic                  ack_q;
	logic [WB_DAT_W-1:0]   dat_q;
	logic                  bus_req;
	logic                  wr_stb;
	logic                  rd_stb;
	logic [IDX_W-1:0]      reg_idx;

	// Register storage and status
	logic                  adv_fd_q;
	logic                  adv_hd_q;
	logic                  adv_multi_q;
	logic                  ms_fault_q;
	logic                  status_rd;
	logic [IDLE_CNT_W-1:0] idle_cnt;
	gps_strap_s            strap_cap;
	logic                  rst_adv_fd;
	logic                  rst_adv_hd;

	// Read views of each register
	logic [REG_W-1:0]      adv_word;
	logic [REG_W-1:0]      status_word;
	logic [REG_W-1:0]      strap_word;
	logic [REG_W-1:0]      rd_word;

	// Request decode; one access per ack
	assign bus_req = cyc_i & stb_i & ~ack_q;
	assign wr_stb  = bus_req & we_i;
	assign rd_stb  = bus_req & ~we_i;
	assign reg_idx = adr_i[IDX_LSB +: IDX_W];

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
		end
	end

	assign ack_o = ack_q;

	// Strap sampling while reset is held
	gps_strap_capture u_strap (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.strap_i (strap_i),
		.strap_o (strap_cap)
	);

	// Gigabit advertisement defaults from live straps during reset
	always_comb begin
		rst_adv_fd = strap_i.an_en && strap_i.speed == SPEED_1000 && strap_i.duplex;
		rst_adv_hd = strap_i.an_en && strap_i.speed == SPEED_1000 && !strap_i.duplex;
	end

	// Advertisement bits, written through byte lane 1 only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adv_fd_q    <= rst_adv_fd;
			adv_hd_q    <= rst_adv_hd;
			adv_multi_q <= strap_i.multi_port;
		end else if (wr_stb && reg_idx == IDX_GIG_ADVERT_CONTROL && sel_i[ADV_WR_LANE]) begin
			adv_fd_q    <= dat_i[ADV_1000FD_BIT];
			adv_hd_q    <= dat_i[ADV_1000HD_BIT];
			adv_multi_q <= dat_i[ADV_MULTI_PORT_BIT];
		end
	end

	assign adv_1000fd_o     = adv_fd_q;
	assign adv_1000hd_o     = adv_hd_q;
	assign adv_multi_port_o = adv_multi_q;

	// A taken read of the link status clears its self-clearing fields
	assign status_rd = rd_stb && reg_idx == IDX_GIG_LINK_STATUS;

	// Fault latch; a fault on the clearing edge wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_fault_q <= 1'b0;
		end else if (link_i.ms_fault) begin
			ms_fault_q <= 1'b1;
		end else if (status_rd) begin
			ms_fault_q <= 1'b0;
		end
	end

	// Idle symbol error count
	gps_sat_counter u_idle_cnt (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.inc_i (link_i.idle_err),
		.clr_i (status_rd),
		.cnt_o (idle_cnt)
	);

	// Advertisement control read view, low byte and top bits zero
	always_comb begin
		adv_word                     = '0;
		adv_word[ADV_MULTI_PORT_BIT] = adv_multi_q;
		adv_word[ADV_1000FD_BIT]     = adv_fd_q;
		adv_word[ADV_1000HD_BIT]     = adv_hd_q;
	end

	// Link status read view, reserved 9:8 zero
	always_comb begin
		status_word                   = '0;
		status_word[LS_MS_FAULT_BIT]  = ms_fault_q;
		status_word[LS_MS_MASTER_BIT] = link_i.ms_master;
		status_word[LS_LOCAL_RX_BIT]  = link_i.local_rx_ok;
		status_word[LS_REMOTE_RX_BIT] = link_i.remote_rx_ok;
		status_word[LS_LP_1000FD_BIT] = link_i.lp_1000fd;
		status_word[LS_LP_1000HD_BIT] = link_i.lp_1000hd;
		status_word[IDLE_CNT_W-1:0]   = idle_cnt;
	end

	// Strap read view from the frozen capture, reserved bits zero
	always_comb begin
		strap_word                                = '0;
		strap_word[SC_AN_EN_BIT]                  = strap_cap.an_en;
		strap_word[SC_DUPLEX_BIT]                 = strap_cap.duplex;
		strap_word[SC_SPEED_LSB +: 2]             = strap_cap.speed;
		strap_word[SC_NC_MODE_BIT]                = strap_cap.nc_mode;
		strap_word[SC_MAC_CLK_BIT]                = strap_cap.mac_clk_en;
		strap_word[SC_XOVER_BIT]                  = strap_cap.auto_crossover_strap;
		strap_word[SC_MULTI_BIT]                  = strap_cap.multi_port;
		strap_word[SC_ADDR_LSB +: 5]              = strap_cap.mgmt_address_strap;
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		case (reg_idx)
			IDX_GIG_ADVERT_CONTROL: begin
				rd_word = adv_word;
			end
			IDX_GIG_LINK_STATUS: begin
				rd_word = status_word;
			end
			IDX_GIG_ABILITY_STATUS: begin
				rd_word = ABILITY_STATUS_VALUE;
			end
			IDX_STRAP_CAPTURE: begin
				rd_word = strap_word;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// Read data registered with the ack, zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= '0;
		end else if (rd_stb) begin
			dat_q <= {{(WB_DAT_W-REG_W){1'b0}}, rd_word};
		end else begin
			dat_q <= '0;
		end
	end

	assign dat_o = dat_q;

	// Presets for the basic, auxiliary and address registers
	always_comb begin
		preset_o.basic_an_en        = strap_cap.an_en;
		preset_o.basic_duplex       = strap_cap.duplex;
		preset_o.basic_speed_msb    = strap_cap.speed[1];
		preset_o.basic_speed_lsb    = strap_cap.speed[0];
		preset_o.aux_nc_mode        = strap_cap.nc_mode;
		preset_o.aux_auto_crossover = strap_cap.auto_crossover_strap;
		preset_o.mac_clk_en         = strap_cap.mac_clk_en;
		preset_o.mgmt_address       = strap_cap.mgmt_address_strap;
	end

endmodule

// ===== tb/gps_regs_properties.sv
`timescale 1ns/100ps
module gps_regs_chk
	import gps_pkg::*;
(
	// Clock, reset and bus
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                cyc_i,
	input wire logic                stb_i,
	input wire logic                we_i,
	input wire logic [WB_ADR_W-1:0] adr_i,
	input wire logic [3:0]          sel_i,
	input wire logic [WB_DAT_W-1:0] dat_i,
	input wire logic                ack_o,
	input wire logic [WB_DAT_W-1:0] dat_o,
	// Straps, link and outputs
	input wire gps_strap_s          strap_i,
	input wire gps_link_s           link_i,
	input wire logic                adv_1000fd_o,
	input wire logic                adv_1000hd_o,
	input wire logic                adv_multi_port_o,
	input wire gps_preset_s         preset_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [IDX_W-1:0] idx_q;
	logic             rd_q;
	// Request as seen at the taking edge
	always_ff @(posedge clk_i) begin
		idx_q <= adr_i[IDX_W+IDX_LSB-1:IDX_LSB];
		rd_q  <= ~we_i;
	end
	property p_ack_one; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack not a single pulse");
	property p_dat_idle; !ack_o |-> dat_o == '0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	property p_ability; ack_o && rd_q && idx_q == IDX_GIG_ABILITY_STATUS |-> dat_o == 32'h00003000;
	endproperty
	a_ability: assert property (p_ability) else $error("ability word wrong");
	property p_adv; ack_o && rd_q && idx_q == IDX_GIG_ADVERT_CONTROL |-> dat_o[7:0] == 8'h00
		&& dat_o[9] == adv_1000fd_o && dat_o[8] == adv_1000hd_o; endproperty
	a_adv: assert property (p_adv) else $error("advert read wrong");
	property p_stat; ack_o && rd_q && idx_q == IDX_GIG_LINK_STATUS |-> dat_o[9:8] == 2'h0
		&& dat_o[14] == $past(link_i.ms_master) && dat_o[11] == $past(link_i.lp_1000fd)
		&& dat_o[10] == $past(link_i.lp_1000hd); endproperty
	a_stat: assert property (p_stat) else $error("status read wrong");
	property p_strap; ack_o && rd_q && idx_q == IDX_STRAP_CAPTURE |-> dat_o[11] == 1'b0
		&& dat_o[9:8] == 2'h0 && dat_o[4:0] == preset_o.mgmt_address
		&& dat_o[15] == preset_o.basic_an_en; endproperty
	a_strap: assert property (p_strap) else $error("strap read wrong");
	property p_frozen; !$past(rst_i) |-> $stable(preset_o); endproperty
	a_frozen: assert property (p_frozen) else $error("presets moved");
	property p_adv_rst; $fell(rst_i) |-> adv_1000fd_o == ($past(strap_i.an_en)
		&& $past(strap_i.speed) == 2'h2 && $past(strap_i.duplex)) && adv_1000hd_o ==
		($past(strap_i.an_en) && $past(strap_i.speed) == 2'h2 && !$past(strap_i.duplex));
	endproperty
	a_adv_rst: assert property (p_adv_rst) else $error("advert reset wrong");
	property p_pre_rst; $fell(rst_i) |-> preset_o.mgmt_address ==
		$past(strap_i.mgmt_address_strap) && preset_o.basic_speed_lsb == $past(strap_i.speed[0]);
	endproperty
	a_pre_rst: assert property (p_pre_rst) else $error("preset capture wrong");
endmodule

bind gps_regs gps_regs_chk i_gps_regs_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
	.dat_o(dat_o), .strap_i(strap_i), .link_i(link_i), .adv_1000fd_o(adv_1000fd_o),
	.adv_1000hd_o(adv_1000hd_o), .adv_multi_port_o(adv_multi_port_o), .preset_o(preset_o));

// ===== tb/gps_link_model.sv
`timescale 1ns/100ps
module gps_link_model
	import gps_pkg::*;
(
	// Clock
	input  wire logic       clk_i,
	// Levels and burst request
	input  wire gps_link_s  lvl_i,
	input  wire logic [8:0] n_i,
	input  wire logic       go_i,
	// Status toward the register block
	output gps_link_s       link_o
);
	logic [8:0] cnt_q = 9'h000;
	// Burst length countdown
	always_ff @(posedge clk_i) begin
		if (go_i) begin
			cnt_q <= n_i;
		end else if (cnt_q != 9'h000) begin
			cnt_q <= cnt_q - 9'h001;
		end
	end
	// Fault and idle errors only inside a burst
	always_comb begin
		link_o          = lvl_i;
		link_o.ms_fault = lvl_i.ms_fault & (cnt_q != 9'h000);
		link_o.idle_err = cnt_q != 9'h000;
	end
endmodule

// ===== tb/test_gps_regs.sv
`timescale 1ns/100ps
module test_gps_regs
	import gps_pkg::*;
;
	logic                clk_i    = 1'b0;
	logic                rst_i    = 1'b1;
	logic                cyc_i    = 1'b0;
	logic                stb_i    = 1'b0;
	logic                we_i     = 1'b0;
	logic [WB_ADR_W-1:0] adr_i    = 8'h00;
	logic [3:0]          sel_i    = 4'h0;
	logic [WB_DAT_W-1:0] dat_i    = 32'h0;
	logic                ack_o;
	logic [WB_DAT_W-1:0] dat_o;
	logic                adv_fd;
	logic                adv_hd;
	logic                adv_mp;
	gps_preset_s         preset;
	logic [3:0]          wsel     = 4'hF;
	gps_strap_s          strap_i  = 13'h1CF5;
	gps_link_s           lvl      = 7'h00;
	gps_link_s           link_i;
	logic [8:0]          burst_n  = 9'h000;
	logic                burst_go = 1'b0;
	logic [15:0]         rd;
	int                  fail_count = 0;
	int                  num_checks = 0;
	gps_strap_s          st [3] = '{13'h1CF5, 13'h1501, 13'h0A9F};

	gps_regs i_gps_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
		.dat_o(dat_o), .strap_i(strap_i), .link_i(link_i), .adv_1000fd_o(adv_fd),
		.adv_1000hd_o(adv_hd), .adv_multi_port_o(adv_mp), .preset_o(preset));
	gps_link_model i_gps_link_model (.clk_i(clk_i), .lvl_i(lvl), .n_i(burst_n),
		.go_i(burst_go), .link_o(link_i));

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	task end_sim;
		if (fail_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic cycle, held until ack is seen
	task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= wsel;
		dat_i <= {16'h0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o[15:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	task burst(input int k);
		@(posedge clk_i);
		burst_n  <= k[8:0];
		burst_go <= 1'b1;
		@(posedge clk_i);
		burst_go <= 1'b0;
		repeat (k + 2) @(posedge clk_i);
	endtask

	function automatic logic [15:0] exp_adv(gps_strap_s s);
		logic g;
		g = s.an_en && s.speed == 2'h2;
		return {5'h00, s.multi_port, g && s.duplex, g && !s.duplex, 8'h00};
	endfunction

	function automatic logic [15:0] exp_pre(gps_strap_s s);
		return {4'h0, s.an_en, s.duplex, s.speed, s.nc_mode, s.auto_crossover_strap,
			s.mac_clk_en, s.mgmt_address_strap};
	endfunction

	function automatic logic [15:0] exp_str(gps_strap_s s);
		return {s.an_en, s.duplex, s.speed, 1'b0, s.nc_mode, 2'h0, s.mac_clk_en,
			s.auto_crossover_strap, s.multi_port, s.mgmt_address_strap};
	endfunction

	// Watchdog
	initial begin
		#500000;
		fail_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (i > 0) begin
				@(posedge clk_i);
				rst_i   <= 1'b1;
				strap_i <= st[i];
				repeat (6) @(posedge clk_i);
				rst_i   <= 1'b0;
			end
			wb(1'b0, 8'h24, 16'h0000);
			chk(rd, exp_adv(st[i]));
			chk({13'h0000, adv_mp, adv_fd, adv_hd}, exp_adv(st[i]) >> 8);
			chk({4'h0, preset}, exp_pre(st[i]));
			wb(1'b1, 8'h40, 16'hF4FF);
			wb(1'b0, 8'h40, 16'h0000);
			chk(rd, exp_str(st[i]));
			wb(1'b1, 8'h24, 16'hFFFF);
			wb(1'b0, 8'h24, 16'h0000);
			chk(rd, 16'h0700);
			chk({13'h0000, adv_mp, adv_fd, adv_hd}, 16'h0007);
			wb(1'b1, 8'h24, 16'h0000);
			wb(1'b0, 8'h24, 16'h0000);
			chk(rd, 16'h0000);
			wsel = 4'hD;
			wb(1'b1, 8'h24, 16'hFFFF);
			wsel = 4'hF;
			wb(1'b0, 8'h24, 16'h0000);
			chk(rd, 16'h0000);
		end
		wb(1'b1, 8'h3C, 16'hFFFF);
		wb(1'b0, 8'h3C, 16'h0000);
		chk(rd, 16'h3000);
		wb(1'b1, 8'h2C, 16'hFFFF);
		wb(1'b0, 8'h2C, 16'h0000);
		chk(rd, 16'h0000);
		lvl <= 7'h7C;
		burst(3);
		wb(1'b0, 8'h28, 16'h0000);
		chk(rd, 16'hF803);
		wb(1'b0, 8'h28, 16'h0000);
		chk(rd, 16'h7800);
		lvl <= 7'h7A;
		burst(300);
		wb(1'b1, 8'h28, 16'hFFFF);
		wb(1'b0, 8'h28, 16'h0000);
		chk(rd, 16'hF4FF);
		end_sim();
	end
endmodule
